// ---- hdl/abrc_top.sv ----
// AXI4 slave turning bus transactions into block RAM port accesses
`timescale 1ns/1ps
//
// Summary of operation
// [R01] Write address taken when valid and ready
// [R02] Two pending write addresses, then ready low
// [R03] Write ready low while memory path busy
// [R04] Full-width writes keep timing with correction on
// [R05] No memory write before address accepted
// [R06] Read ready registered, high by default
// [R07] Two pending read addresses, then ready low
// [R08] Same-cycle read ready accepted, beat retired
// [R09] Single read: last with valid
// [R10] No read data before address handshake
// [R11] Write address ready ignores write valid
// [R12] Length is beats minus one; size gives width
// [R13] Each narrow beat one memory write, masked with correction off, a full merged word with correction on
// [R14] Narrow lanes rotate with running address
// [R15] Word address advances only at word boundary
// [R16] Unaligned start masks lanes of first beat
// [R17] Transaction IDs returned on response channels
// [R18] Correction on: partial writes read-modify-write
// [R19] Memory enable only during real accesses
// [R20] Okay response after last beat, held
// [R21] Read last only on final counted beat
module abrc_top #(
   parameter bit ECC_EN = 1'b0
) (
   input  wire logic                      clk,
   input  wire logic                      nrst,
   input  wire logic [abrc_pkg::ID_W-1:0] s_axi_awid,
   input  wire logic [abrc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [7:0]                s_axi_awlen,
   input  wire logic [2:0]                s_axi_awsize,
   input  wire logic [1:0]                s_axi_awburst,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [abrc_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [abrc_pkg::STRB_W-1:0] s_axi_wstrb,
   input  wire logic                      s_axi_wlast,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [abrc_pkg::ID_W-1:0]      s_axi_bid,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [abrc_pkg::ID_W-1:0] s_axi_arid,
   input  wire logic [abrc_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [7:0]                s_axi_arlen,
   input  wire logic [2:0]                s_axi_arsize,
   input  wire logic [1:0]                s_axi_arburst,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [abrc_pkg::ID_W-1:0]      s_axi_rid,
   output logic [abrc_pkg::DATA_W-1:0]    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rlast,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output logic [abrc_pkg::RAM_AW-1:0]    ram_word_address,
   output logic [abrc_pkg::STRB_W-1:0]    ram_byte_write_enables,
   output logic                           ram_port_enable,
   output logic [abrc_pkg::DATA_W-1:0]    ram_write_word,
   input  wire logic [abrc_pkg::DATA_W-1:0] ram_read_word
);
   localparam int BA_W = abrc_pkg::BA_W;
   localparam int AW   = abrc_pkg::RAM_AW;
   localparam int DW   = abrc_pkg::DATA_W;
   localparam int SW   = abrc_pkg::STRB_W;

   // Lanes of one beat: inside the sized container, at or above the address
   function automatic logic [3:0] lane_mask(input logic [1:0] a, input logic [2:0] sz);
      logic [3:0] span;
      logic [1:0] base;
      span = (sz >= abrc_pkg::SIZE_WORD) ? 4'hF : (sz == abrc_pkg::SIZE_HALF) ? 4'h3 : 4'h1;
      base = (sz >= abrc_pkg::SIZE_WORD) ? 2'h0 : (sz == abrc_pkg::SIZE_HALF) ? {a[1], 1'b0} : a;
      lane_mask = (span << base) & (4'hF << a);
   endfunction : lane_mask

   // Fixed bursts run as incrementing ones; wrap stays inside its window
   function automatic logic [BA_W-1:0] next_addr(input abrc_pkg::abrc_cmd_type c);
      logic [BA_W-1:0] step, inc, wmask;
      step  = BA_W'(1) << c.size;
      inc   = (c.addr & ~(step - BA_W'(1))) + step;
      wmask = ((BA_W'(c.len) + BA_W'(1)) << c.size) - BA_W'(1);
      if (c.burst == abrc_pkg::BURST_WRAP)
         next_addr = (c.addr & ~wmask) | (inc & wmask);
      else
         next_addr = inc;
   endfunction : next_addr

   function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w, input logic [DW-1:0] new_w,
                                           input logic [SW-1:0] we);
      for (int i = 0; i < SW; i++)
         merge[i*8 +: 8] = we[i] ? new_w[i*8 +: 8] : old_w[i*8 +: 8];
   endfunction : merge

   abrc_pkg::abrc_cmd_type   aw_in, aw_out, ar_in, ar_out;
   abrc_pkg::abrc_rbeat_type rb_in, rb_out;
   logic       aw_out_v, ar_out_v, aw_pop, ar_pop, rb_in_ready;
   logic [1:0] aw_lvl, ar_lvl, rb_lvl;

   assign aw_in = '{s_axi_awid, s_axi_awaddr[BA_W-1:0], s_axi_awlen, s_axi_awsize, s_axi_awburst};
   assign ar_in = '{s_axi_arid, s_axi_araddr[BA_W-1:0], s_axi_arlen, s_axi_arsize, s_axi_arburst};

   // Address queues; ready is a flop and never looks at the data channel
   abrc_buf2 #(.W($bits(abrc_pkg::abrc_cmd_type))) u_awq (  // [R01] [R02] [R11]
      .clk(clk), .nrst(nrst), .in_valid(s_axi_awvalid), .in_ready(s_axi_awready), .in_data(aw_in),
      .out_valid(aw_out_v), .out_ready(aw_pop), .out_data(aw_out), .level(aw_lvl));
   abrc_buf2 #(.W($bits(abrc_pkg::abrc_cmd_type))) u_arq (  // [R06] [R07]
      .clk(clk), .nrst(nrst), .in_valid(s_axi_arvalid), .in_ready(s_axi_arready), .in_data(ar_in),
      .out_valid(ar_out_v), .out_ready(ar_pop), .out_data(ar_out), .level(ar_lvl));

   // Write engine state
   abrc_pkg::abrc_wstate_type ws_r, ws_nxt;
   abrc_pkg::abrc_cmd_type    wc_r, wc_nxt;
   logic [7:0]    wcnt_r, wcnt_nxt;
   logic          wready_r, wready_nxt, bvalid_r, bvalid_nxt;
   logic [DW-1:0] bt_data_r, bt_data_nxt;
   logic [SW-1:0] bt_we_r, bt_we_nxt;
   logic [AW-1:0] bt_addr_r, bt_addr_nxt;
   logic          bt_last_r, bt_last_nxt;
   logic          w_acc, w_last, rmw, wr_port;
   logic [SW-1:0] bmask, wr_we;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;

   always_comb begin
      w_acc       = s_axi_wvalid && wready_r;
      w_last      = (wcnt_r == abrc_pkg::LEN_LAST);  // [R12]
      bmask       = lane_mask(wc_r.addr[1:0], wc_r.size) & s_axi_wstrb;  // [R13] [R14] [R16]
      // Full-width beats skip the read so their timing is unchanged
      rmw         = ECC_EN && (bmask != abrc_pkg::STRB_ALL);  // [R04] [R18]
      aw_pop      = 1'b0;
      ws_nxt      = ws_r;
      wc_nxt      = wc_r;
      wcnt_nxt    = wcnt_r;
      wready_nxt  = wready_r;
      bvalid_nxt  = bvalid_r;
      bt_data_nxt = bt_data_r;
      bt_we_nxt   = bt_we_r;
      bt_addr_nxt = bt_addr_r;
      bt_last_nxt = bt_last_r;
      wr_port     = 1'b0;
      wr_we       = abrc_pkg::STRB_NONE;
      wr_addr     = wc_r.addr[BA_W-1:2];  // [R15]
      wr_data     = s_axi_wdata;
      case (ws_r)
         abrc_pkg::W_IDLE: begin
            // Data is only taken once an address is loaded
            if (aw_out_v) begin  // [R05]
               aw_pop     = 1'b1;
               wc_nxt     = aw_out;
               wcnt_nxt   = aw_out.len;
               ws_nxt     = abrc_pkg::W_DATA;
               wready_nxt = 1'b1;
            end
         end
         abrc_pkg::W_DATA: begin
            if (w_acc) begin
               wr_port     = 1'b1;
               wr_we       = rmw ? abrc_pkg::STRB_NONE : bmask;  // [R13]
               wc_nxt.addr = next_addr(wc_r);  // [R14] [R15]
               wcnt_nxt    = wcnt_r - abrc_pkg::LEN_STEP;
               bt_data_nxt = s_axi_wdata;
               bt_we_nxt   = bmask;
               bt_addr_nxt = wc_r.addr[BA_W-1:2];
               bt_last_nxt = w_last;
               if (rmw) begin  // [R18]
                  ws_nxt     = abrc_pkg::W_RMW_WAIT;
                  wready_nxt = 1'b0;  // [R03]
               end else if (w_last) begin
                  ws_nxt     = abrc_pkg::W_BWAIT;
                  wready_nxt = 1'b0;  // [R03]
               end
            end
         end
         abrc_pkg::W_RMW_WAIT: ws_nxt = abrc_pkg::W_RMW_WR;
         abrc_pkg::W_RMW_WR: begin
            wr_port = 1'b1;
            wr_we   = abrc_pkg::STRB_ALL;
            wr_addr = bt_addr_r;
            wr_data = merge(ram_read_word, bt_data_r, bt_we_r);  // [R18]
            if (bt_last_r) begin
               ws_nxt = abrc_pkg::W_BWAIT;
            end else begin
               ws_nxt     = abrc_pkg::W_DATA;
               wready_nxt = 1'b1;
            end
         end
         abrc_pkg::W_BWAIT: begin
            ws_nxt     = abrc_pkg::W_RESP;
            bvalid_nxt = 1'b1;  // [R20]
         end
         abrc_pkg::W_RESP: begin
            if (s_axi_bready) begin  // [R20]
               bvalid_nxt = 1'b0;
               ws_nxt     = abrc_pkg::W_IDLE;
            end
         end
         default: ws_nxt = abrc_pkg::W_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ws_r      <= abrc_pkg::W_IDLE;
         wc_r      <= '0;
         wcnt_r    <= '0;
         wready_r  <= 1'b0;
         bvalid_r  <= 1'b0;
         bt_data_r <= '0;
         bt_we_r   <= '0;
         bt_addr_r <= '0;
         bt_last_r <= 1'b0;
      end else begin
         ws_r      <= ws_nxt;
         wc_r      <= wc_nxt;
         wcnt_r    <= wcnt_nxt;
         wready_r  <= wready_nxt;
         bvalid_r  <= bvalid_nxt;
         bt_data_r <= bt_data_nxt;
         bt_we_r   <= bt_we_nxt;
         bt_addr_r <= bt_addr_nxt;
         bt_last_r <= bt_last_nxt;
      end
   end

   // Read engine state; at most two beats in flight or buffered
   abrc_pkg::abrc_rstate_type rs_r, rs_nxt;
   abrc_pkg::abrc_cmd_type    rc_r, rc_nxt;
   logic [7:0]          rcnt_r, rcnt_nxt;
   logic                rd_issue, credit;
   logic                p1_v_r, p1_l_r, p2_v_r, p2_l_r;
   logic [abrc_pkg::ID_W-1:0] p1_id_r, p2_id_r;

   always_comb begin
      credit   = (rb_lvl + {1'b0, p1_v_r} + {1'b0, p2_v_r}) < abrc_pkg::LEVEL_FULL;
      ar_pop   = 1'b0;
      rd_issue = 1'b0;
      rs_nxt   = rs_r;
      rc_nxt   = rc_r;
      rcnt_nxt = rcnt_r;
      case (rs_r)
         abrc_pkg::R_IDLE: begin
            if (ar_out_v) begin  // [R10]
               ar_pop   = 1'b1;
               rc_nxt   = ar_out;
               rcnt_nxt = ar_out.len;  // [R12]
               rs_nxt   = abrc_pkg::R_RUN;
            end
         end
         abrc_pkg::R_RUN: begin
            // Writes own the port in any cycle they need it
            if (!wr_port && credit) begin
               rd_issue    = 1'b1;
               rc_nxt.addr = next_addr(rc_r);
               rcnt_nxt    = rcnt_r - abrc_pkg::LEN_STEP;
               if (rcnt_r == abrc_pkg::LEN_LAST)
                  rs_nxt = abrc_pkg::R_IDLE;
            end
         end
         default: rs_nxt = abrc_pkg::R_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rs_r    <= abrc_pkg::R_IDLE;
         rc_r    <= '0;
         rcnt_r  <= '0;
         p1_v_r  <= 1'b0;
         p1_l_r  <= 1'b0;
         p1_id_r <= '0;
         p2_v_r  <= 1'b0;
         p2_l_r  <= 1'b0;
         p2_id_r <= '0;
      end else begin
         rs_r    <= rs_nxt;
         rc_r    <= rc_nxt;
         rcnt_r  <= rcnt_nxt;
         p1_v_r  <= rd_issue;
         p1_l_r  <= (rcnt_r == abrc_pkg::LEN_LAST);  // [R09] [R21]
         p1_id_r <= rc_r.id;  // [R17]
         p2_v_r  <= p1_v_r;
         p2_l_r  <= p1_l_r;
         p2_id_r <= p1_id_r;
      end
   end

   assign rb_in = '{p2_id_r, ram_read_word, p2_l_r};

   abrc_buf2 #(.W($bits(abrc_pkg::abrc_rbeat_type))) u_rbuf (  // [R08]
      .clk(clk), .nrst(nrst), .in_valid(p2_v_r), .in_ready(rb_in_ready), .in_data(rb_in),
      .out_valid(s_axi_rvalid), .out_ready(s_axi_rready), .out_data(rb_out), .level(rb_lvl));

   // Memory port registers
   logic          ram_en_r, ram_en_nxt;
   logic [SW-1:0] ram_we_r, ram_we_nxt;
   logic [AW-1:0] ram_ad_r, ram_ad_nxt;
   logic [DW-1:0] ram_wd_r, ram_wd_nxt;

   always_comb begin
      ram_en_nxt = wr_port || rd_issue;  // [R19]
      ram_we_nxt = wr_port ? wr_we : abrc_pkg::STRB_NONE;
      ram_ad_nxt = wr_port ? wr_addr : rc_r.addr[BA_W-1:2];
      ram_wd_nxt = wr_port ? wr_data : ram_wd_r;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ram_en_r <= 1'b0;
         ram_we_r <= '0;
         ram_ad_r <= '0;
         ram_wd_r <= '0;
      end else begin
         ram_en_r <= ram_en_nxt;
         ram_we_r <= ram_we_nxt;
         ram_ad_r <= ram_ad_nxt;
         ram_wd_r <= ram_wd_nxt;
      end
   end

   assign s_axi_wready           = wready_r;
   assign s_axi_bvalid           = bvalid_r;
   assign s_axi_bid              = wc_r.id;  // [R17]
   assign s_axi_bresp            = abrc_pkg::RESP_OKAY;
   assign s_axi_rid              = rb_out.id;  // [R17]
   assign s_axi_rdata            = rb_out.data;
   assign s_axi_rlast            = rb_out.last;
   assign s_axi_rresp            = abrc_pkg::RESP_OKAY;
   assign ram_port_enable        = ram_en_r;
   assign ram_byte_write_enables = ram_we_r;
   assign ram_word_address       = ram_ad_r;
   assign ram_write_word         = ram_wd_r;

   // Checks
   logic ar_seen_r;
   always_ff @(posedge clk) begin
      if (!nrst)
         ar_seen_r <= 1'b0;
      else if (s_axi_arvalid && s_axi_arready)
         ar_seen_r <= 1'b1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_rmw_read;
      ram_en_r && (ram_we_r == abrc_pkg::STRB_NONE);
   endsequence
   sequence s_rmw_write;
      ram_en_r && (ram_we_r == abrc_pkg::STRB_ALL);
   endsequence

   chk_aw_full_low: assert property ((aw_lvl == 2'h2) |-> !s_axi_awready)  // [R02]
      else $error("write address ready high while queue full");
   chk_aw_empty_high: assert property ((aw_lvl == 2'h0) |-> s_axi_awready)  // [R01] [R11]
      else $error("write address ready low with empty queue");
   chk_ar_full_low: assert property ((ar_lvl == 2'h2) |-> !s_axi_arready)  // [R07]
      else $error("read address ready high while queue full");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))  // [R08]
      else $error("read beat dropped before acceptance");
   chk_rlast_final: assert property (rd_issue && (rcnt_r == 8'h00) |-> ##2 (p2_v_r && p2_l_r))  // [R09] [R21]
      else $error("final read beat lost its last flag");
   chk_no_spec_read: assert property (s_axi_rvalid |-> ar_seen_r)  // [R10]
      else $error("read data without address handshake");
   chk_rbuf_room: assert property (p2_v_r |-> rb_in_ready)  // [R08]
      else $error("read buffer overrun");
   chk_ram_en_cause: assert property (ram_en_r |-> $past(wr_port || rd_issue))  // [R19]
      else $error("memory enable without an access");
   chk_full_beat_time: assert property (w_acc && !rmw |=> ram_en_r && ram_we_r == $past(bmask))  // [R04] [R13] [R16]
      else $error("beat not written next cycle with its lanes");
   chk_rmw_steps: assert property (w_acc && rmw |=> s_rmw_read ##1 1'b1 ##1 s_rmw_write)  // [R18]
      else $error("partial write not read-modify-write");
   chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bid))  // [R20] [R17]
      else $error("write response dropped before acceptance");
   chk_no_early_w: assert property (s_axi_wready |-> ws_r inside {abrc_pkg::W_DATA})  // [R05] [R03]
      else $error("write data ready outside a loaded burst");
endmodule : abrc_top

// ---- hdl/abrc_pkg.sv ----
// Package: constants, carriers and states of the AXI block RAM controller
package abrc_pkg;
   localparam int DATA_W = 32;
   localparam int STRB_W = 4;
   localparam int ID_W   = 4;
   localparam int ADDR_W = 32;
   localparam int RAM_AW = 11;
   localparam int BA_W   = RAM_AW + 2;
   localparam int QDEPTH = 2;
   localparam logic [1:0] BURST_FIXED = 2'h0;
   localparam logic [1:0] BURST_INCR  = 2'h1;
   localparam logic [1:0] BURST_WRAP  = 2'h2;
   localparam logic [2:0] SIZE_HALF   = 3'h1;
   localparam logic [2:0] SIZE_WORD   = 3'h2;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [7:0] LEN_LAST    = 8'h00;
   localparam logic [7:0] LEN_STEP    = 8'h01;
   localparam logic [STRB_W-1:0] STRB_ALL  = 4'hF;
   localparam logic [STRB_W-1:0] STRB_NONE = 4'h0;
   localparam logic [1:0] LEVEL_FULL  = 2'h2;

   typedef struct packed {
      logic [ID_W-1:0] id;
      logic [BA_W-1:0] addr;
      logic [7:0]      len;
      logic [2:0]      size;
      logic [1:0]      burst;
   } abrc_cmd_type;

   typedef struct packed {
      logic [ID_W-1:0]   id;
      logic [DATA_W-1:0] data;
      logic              last;
   } abrc_rbeat_type;

   typedef enum logic [2:0] {
      W_IDLE = 3'h0, W_DATA = 3'h1, W_RMW_WAIT = 3'h2,
      W_RMW_WR = 3'h3, W_BWAIT = 3'h4, W_RESP = 3'h5
   } abrc_wstate_type;

   typedef enum logic [0:0] {R_IDLE = 1'h0, R_RUN = 1'h1} abrc_rstate_type;
endpackage : abrc_pkg

// ---- hdl/abrc_buf2.sv ----
// Two-entry registered buffer with valid and ready on both sides
`timescale 1ns/1ps
module abrc_buf2 #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data,
   output logic [1:0]        level
);
   logic         out_v_r, out_v_nxt, sk_v_r, sk_v_nxt;
   logic         in_rdy_r, in_rdy_nxt;
   logic [W-1:0] out_d_r, out_d_nxt, sk_d_r, sk_d_nxt;
   logic         push, pop;

   // Ready is its own flop mirroring a free skid slot, so it never depends on out_ready
   assign in_ready  = in_rdy_r;
   assign out_valid = out_v_r;
   assign out_data  = out_d_r;
   assign level     = {1'b0, out_v_r} + {1'b0, sk_v_r};

   always_comb begin
      push      = in_valid && !sk_v_r;
      pop       = out_v_r && out_ready;
      out_v_nxt = out_v_r;
      out_d_nxt = out_d_r;
      sk_v_nxt  = sk_v_r;
      sk_d_nxt  = sk_d_r;
      if (!out_v_r || pop) begin
         if (sk_v_r) begin
            out_v_nxt = 1'b1;
            out_d_nxt = sk_d_r;
            sk_v_nxt  = 1'b0;
         end else begin
            out_v_nxt = push;
            out_d_nxt = push ? in_data : out_d_r;
         end
      end else if (push) begin
         sk_v_nxt = 1'b1;
         sk_d_nxt = in_data;
      end
      in_rdy_nxt = !sk_v_nxt;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         out_v_r <= 1'b0;
         sk_v_r  <= 1'b0;
         out_d_r <= '0;
         sk_d_r  <= '0;
         in_rdy_r <= 1'b1;
      end else begin
         out_v_r <= out_v_nxt;
         sk_v_r  <= sk_v_nxt;
         out_d_r <= out_d_nxt;
         sk_d_r  <= sk_d_nxt;
         in_rdy_r <= in_rdy_nxt;
      end
   end
endmodule : abrc_buf2

// ---- sim/abrc_ram_model.sv ----
// Behavioural one-cycle block RAM behind the controller
`timescale 1ns/1ps
module abrc_ram_model (
   input  wire logic                        clk,
   input  wire logic                        ram_port_enable,
   input  wire logic [abrc_pkg::STRB_W-1:0] ram_byte_write_enables,
   input  wire logic [abrc_pkg::RAM_AW-1:0] ram_word_address,
   input  wire logic [abrc_pkg::DATA_W-1:0] ram_write_word,
   output logic      [abrc_pkg::DATA_W-1:0] ram_read_word
);
   logic [abrc_pkg::DATA_W-1:0] mem [0:2047];
   int                          n_wr;
   initial begin
      n_wr = 0;
      ram_read_word = '0;
      for (int i = 0; i < 2048; i++) mem[i] = '0;
   end
   // Read word lives one cycle, then toggles so a late sample cannot pass
   always @(posedge clk) begin
      if (ram_port_enable && ram_byte_write_enables == 4'h0) ram_read_word <= mem[ram_word_address];
      else ram_read_word <= ~ram_read_word;
      if (ram_port_enable && ram_byte_write_enables != 4'h0) n_wr++;
      for (int b = 0; b < 4; b++) begin
         if (ram_port_enable && ram_byte_write_enables[b]) mem[ram_word_address][8*b +: 8] <= ram_write_word[8*b +: 8];
      end
   end
endmodule : abrc_ram_model

// ---- sim/abrc_top_test.sv ----
// Self-checking bench for the AXI block RAM controller
`timescale 1ns/1ps
module abrc_top_test;
   logic        clk, nrst;
   logic [3:0]  s_axi_awid, s_axi_bid, s_axi_arid, s_axi_rid, s_axi_wstrb, ram_byte_write_enables;
   logic [31:0] s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_rdata, ram_write_word, ram_read_word;
   logic [7:0]  s_axi_awlen, s_axi_arlen;
   logic [2:0]  s_axi_awsize, s_axi_arsize;
   logic [1:0]  s_axi_awburst, s_axi_arburst, s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wlast, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rlast, s_axi_rvalid, s_axi_rready;
   logic [10:0] ram_word_address;
   logic        ram_port_enable;
   int          err_count, n_compared;

   // Correction on, so partial beats take the read-modify-write path
   abrc_top #(.ECC_EN(1'b1)) dut (.clk, .nrst, .s_axi_awid, .s_axi_awaddr, .s_axi_awlen, .s_axi_awsize, .s_axi_awburst,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wlast, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arid, .s_axi_araddr, .s_axi_arlen,
      .s_axi_arsize, .s_axi_arburst, .s_axi_arvalid, .s_axi_arready, .s_axi_rid, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rlast, .s_axi_rvalid, .s_axi_rready, .ram_word_address, .ram_byte_write_enables,
      .ram_port_enable, .ram_write_word, .ram_read_word);
   abrc_ram_model ram (.clk, .ram_port_enable, .ram_byte_write_enables, .ram_word_address,
      .ram_write_word, .ram_read_word);

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task stop_test;
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test
   task tmo;
      err_count++;
      $display("mismatch at %0t: handshake timed out", $time);
      stop_test;
   endtask : tmo
   task aw(input logic [3:0] id, input logic [31:0] a, input logic [7:0] len, input logic [2:0] sz);
      int i;
      {s_axi_awid, s_axi_awaddr, s_axi_awlen, s_axi_awsize, s_axi_awvalid} = {id, a, len, sz, 1'b1};
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (s_axi_awready === 1'b1) break;
      end
      if (i == 50) tmo;
      #1 s_axi_awvalid = 1'b0;
   endtask : aw
   task wb(input logic [31:0] d, input logic [3:0] s, input logic l);
      int i;
      {s_axi_wdata, s_axi_wstrb, s_axi_wlast, s_axi_wvalid} = {d, s, l, 1'b1};
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (s_axi_wready === 1'b1) break;
      end
      if (i == 50) tmo;
      #1;
      // Valid stays up inside a burst so the next beat never rewrites it in one step
      if (l) s_axi_wvalid = 1'b0;
   endtask : wb
   task brsp(input logic [3:0] id);
      int i;
      s_axi_bready = 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (s_axi_bvalid === 1'b1) break;
      end
      if (i == 50) tmo;
      chk(s_axi_bid, id);
      chk(s_axi_bresp, abrc_pkg::RESP_OKAY);
      #1 s_axi_bready = 1'b0;
   endtask : brsp
   // Ready is held up ahead of valid, so same-cycle acceptance is exercised
   task rd(input logic [3:0] id, input logic [31:0] a, input logic [7:0] len, input logic [31:0] e0, e1);
      int i;
      chk(s_axi_rvalid, 1'b0);
      chk(s_axi_arready, 1'b1);
      {s_axi_arid, s_axi_araddr, s_axi_arlen, s_axi_arvalid} = {id, a, len, 1'b1};
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (s_axi_arready === 1'b1) break;
      end
      if (i == 50) tmo;
      #1 s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b1;
      for (int k = 0; k <= len; k++) begin
         for (i = 0; i < 50; i++) begin
            @(posedge clk);
            if (s_axi_rvalid === 1'b1) break;
         end
         if (i == 50) tmo;
         chk(s_axi_rdata, k == 0 ? e0 : e1);
         chk(s_axi_rid, id);
         chk(s_axi_rresp, abrc_pkg::RESP_OKAY);
         chk(s_axi_rlast, k == len);
      end
      #1 chk(s_axi_rvalid, 1'b0);
      s_axi_rready = 1'b0;
   endtask : rd

   task t_single;
      aw(4'h5, 32'h1000, 8'h00, abrc_pkg::SIZE_WORD);
      wb(32'hA5A55A5A, 4'hF, 1'b1);
      chk(s_axi_wready, 1'b0);
      brsp(4'h5);
      chk(ram.mem[11'h400], 32'hA5A55A5A);
      rd(4'h9, 32'h1000, 8'h00, 32'hA5A55A5A, 32'h0);
      $display("single done");
   endtask : t_single
   task t_narrow;
      int w0;
      w0 = ram.n_wr;
      aw(4'h3, 32'h1010, 8'h03, abrc_pkg::SIZE_HALF);
      for (int k = 0; k < 4; k++) wb(32'(32'h11111111 * (k + 1)), k[0] ? 4'hC : 4'h3, k == 3);
      brsp(4'h3);
      chk(ram.n_wr - w0, 4);
      chk(ram.mem[11'h404], 32'h22221111);
      chk(ram.mem[11'h405], 32'h44443333);
      rd(4'hA, 32'h1010, 8'h01, 32'h22221111, 32'h44443333);
      $display("narrow done");
   endtask : t_narrow
   task t_unal;
      aw(4'h6, 32'h1022, 8'h01, abrc_pkg::SIZE_WORD);
      // Full strobes: the lanes of the first beat must come from the address
      wb(32'hAABBCCDD, 4'hF, 1'b0);
      wb(32'h12345678, 4'hF, 1'b1);
      brsp(4'h6);
      chk(ram.mem[11'h408], 32'hAABB0000);
      chk(ram.mem[11'h409], 32'h12345678);
      $display("unaligned done");
   endtask : t_unal
   task t_early;
      int w0;
      w0 = ram.n_wr;
      {s_axi_wdata, s_axi_wstrb, s_axi_wlast, s_axi_wvalid} = {32'hC3C3C3C3, 4'hF, 1'b1, 1'b1};
      repeat (4) begin
         @(posedge clk);
         #1 chk(ram_port_enable, 1'b0);
         chk(s_axi_wready, 1'b0);
      end
      chk(ram.n_wr - w0, 0);
      aw(4'h7, 32'h1030, 8'h00, abrc_pkg::SIZE_WORD);
      wb(32'hC3C3C3C3, 4'hF, 1'b1);
      brsp(4'h7);
      chk(ram.mem[11'h40C], 32'hC3C3C3C3);
      $display("early data done");
   endtask : t_early
   task t_pipe;
      int n;
      n = 0;
      {s_axi_awlen, s_axi_awsize, s_axi_awvalid} = {8'h00, abrc_pkg::SIZE_WORD, 1'b1};
      repeat (8) begin
         {s_axi_awid, s_axi_awaddr} = {n[3:0], 32'(32'h1040 + 4 * n)};
         @(posedge clk);
         if (s_axi_awready === 1'b1) n++;
         #1;
      end
      chk(n, 3);
      chk(s_axi_awready, 1'b0);
      for (int k = 0; k < 4; k++) begin
         if (k == 1) aw(4'h3, 32'h104C, 8'h00, abrc_pkg::SIZE_WORD);
         wb(32'(32'hB0000000 + k), 4'hF, 1'b1);
         brsp(k[3:0]);
         chk(ram.mem[11'h410 + k], 32'(32'hB0000000 + k));
      end
      $display("pipeline done");
   endtask : t_pipe

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      {err_count, n_compared, nrst} = '0;
      {s_axi_awid, s_axi_awaddr, s_axi_awlen, s_axi_awsize, s_axi_awvalid} = '0;
      {s_axi_arid, s_axi_araddr, s_axi_arlen, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_wdata, s_axi_wstrb, s_axi_wlast, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_awburst, s_axi_arburst} = {abrc_pkg::BURST_INCR, abrc_pkg::BURST_INCR};
      s_axi_arsize = abrc_pkg::SIZE_WORD;
      repeat (8) @(posedge clk);
      #1 nrst = 1'b1;
      @(posedge clk);
      #1;
      t_single;
      t_narrow;
      t_unal;
      t_early;
      t_pipe;
      stop_test;
   end
endmodule : abrc_top_test
